/* File: include/abx_regs.vh */
// opcode fields, reset values and file addresses for the add and bit-ops execution unit
// Operation
// RULE1: add immediate to acc, flags C DC Z
// RULE2: and immediate with acc, only Z
// RULE3: add acc with file, d selects destination
// RULE4: and acc with file, d selects, only Z
// RULE5: clear selected file bit, flags untouched
// RULE6: set selected file bit, flags untouched
// RULE7: tested bit one: next instruction runs, one cycle
// RULE8: tested bit zero: next becomes nop, two cycles
// RULE9: taken test costs second cycle as nop
// RULE10: port read-modify-write reads pin levels
// RULE11: timer-zero write clears assigned prescaler
// RULE12: Z on zero result; C bit7, DC bit3
`ifndef ABX_REGS_VH
`define ABX_REGS_VH
`define ABX_OP_ADD_FILE_HI 6'h07
`define ABX_OP_AND_FILE_HI 6'h05
`define ABX_OP_BITCLR_HI 4'h4
`define ABX_OP_BITSET_HI 4'h5
`define ABX_OP_BITTST_HI 4'h6
`define ABX_OP_ADD_IMM_HI 5'h1f
`define ABX_OP_AND_IMM_HI 6'h39
`define ABX_ACC_RST 8'h00
`define ABX_FLAG_RST 1'b0
`define ABX_D_BIT 7
`define ABX_TIMER_ZERO_ADDR 7'h01
`define ABX_PIN_RST 1'b0
`define ABX_PORT_LO_ADDR 7'h05
`define ABX_PORT_HI_ADDR 7'h09
`endif

/* File: logic/abx_exec.v */
// execution unit for add, and, bit set/clear and bit-test-skip instructions
`timescale 1ns/100ps
`include "abx_regs.vh"
module abx_exec (
  input wire clk_sys,
  input wire rst,
  input wire instr_valid,
  input wire [13:0] instr_word,
  output wire [6:0] file_addr,
  input wire [7:0] file_rdata,
  input wire [7:0] pin_rdata,
  input wire prescaler_on_timer,
  output reg file_we_q,
  output reg [6:0] file_waddr_q,
  output reg [7:0] file_wdata_q,
  output reg prescaler_clr_q,
  output reg [7:0] acc_q,
  output reg carry_q,
  output reg digit_carry_q,
  output reg zero_q,
  output wire skip_cycle,
  output reg illegal_q
);
  localparam ST_RUN = 2'h1;
  localparam ST_NOP = 2'h2;
  wire is_add_file;
  wire is_and_file;
  wire is_bclr;
  wire is_bset;
  wire is_btst;
  wire is_add_imm;
  wire is_and_imm;
  wire is_known;
  wire dest_file;
  wire [2:0] bit_idx;
  wire [7:0] lit;
  wire is_port;
  wire hits_timer;
  wire [7:0] pin_lvl;
  wire [7:0] src;
  wire [7:0] addend;
  wire [4:0] low_sum;
  wire [8:0] full_sum;
  wire [7:0] and_res;
  wire [7:0] bit_mask;
  wire do_add;
  wire do_and;
  wire go;
  wire nop_slot;
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg skip_d;
  reg [7:0] res;
  reg wr_file;
  reg wr_acc;
  reg [7:0] acc_d;
  reg carry_d;
  reg digit_carry_d;
  reg zero_d;
  genvar gi;

  assign nop_slot = (state_q == ST_NOP);
  assign go = instr_valid & ~nop_slot;
  assign is_add_file = instr_word[13:8] == `ABX_OP_ADD_FILE_HI;
  assign is_and_file = instr_word[13:8] == `ABX_OP_AND_FILE_HI;
  assign is_bclr = instr_word[13:10] == `ABX_OP_BITCLR_HI;
  assign is_bset = instr_word[13:10] == `ABX_OP_BITSET_HI;
  assign is_btst = instr_word[13:10] == `ABX_OP_BITTST_HI;
  assign is_add_imm = instr_word[13:9] == `ABX_OP_ADD_IMM_HI;
  assign is_and_imm = instr_word[13:8] == `ABX_OP_AND_IMM_HI;
  assign is_known = do_add | do_and | is_bclr | is_bset | is_btst;
  assign dest_file = instr_word[`ABX_D_BIT];
  assign bit_idx = instr_word[9:7];
  assign lit = instr_word[7:0];
  assign file_addr = instr_word[6:0];
  assign hits_timer = (file_addr == `ABX_TIMER_ZERO_ADDR);
  // port reads take the pin levels
  assign is_port = (file_addr >= `ABX_PORT_LO_ADDR) && (file_addr <= `ABX_PORT_HI_ADDR); // RULE10
  assign src = is_port ? pin_lvl : file_rdata; // RULE10
  assign addend = (is_add_imm | is_and_imm) ? lit : src;
  assign low_sum = {1'b0, acc_q[3:0]} + {1'b0, addend[3:0]}; // RULE12
  assign full_sum = {1'b0, acc_q} + {1'b0, addend}; // RULE12
  assign and_res = acc_q & addend;
  assign bit_mask = 8'h01 << bit_idx;
  assign do_add = is_add_file | is_add_imm;
  assign do_and = is_and_file | is_and_imm;
  // second cycle of a taken skip behaves as nop
  assign skip_cycle = nop_slot; // RULE9

  // pin levels: four flops, change taken once second and third agree
  generate
    for (gi = 0; gi < 8; gi = gi + 1)
    begin : g_pin_sync
      reg meta_q;
      reg mid_q;
      reg last_q;
      reg lvl_q;
      wire lvl_d;
      assign lvl_d = (mid_q == last_q) ? last_q : lvl_q;
      assign pin_lvl[gi] = lvl_q; // RULE10
      always @(posedge clk_sys)
      begin
        if (rst)
        begin
          meta_q <= `ABX_PIN_RST;
          mid_q <= `ABX_PIN_RST;
          last_q <= `ABX_PIN_RST;
          lvl_q <= `ABX_PIN_RST;
        end
        else
        begin
          meta_q <= pin_rdata[gi];
          mid_q <= meta_q;
          last_q <= mid_q;
          lvl_q <= lvl_d;
        end
      end
    end
  endgenerate

  always @*
  begin
    res = 8'h00;
    wr_file = 1'b0;
    wr_acc = 1'b0;
    skip_d = 1'b0;
    if (go)
    begin
      if (do_add)
      begin
        res = full_sum[7:0]; // RULE1 RULE3
        wr_file = is_add_file & dest_file; // RULE3
        wr_acc = is_add_imm | (is_add_file & ~dest_file); // RULE1 RULE3
      end
      else if (do_and)
      begin
        res = and_res; // RULE2 RULE4
        wr_file = is_and_file & dest_file; // RULE4
        wr_acc = is_and_imm | (is_and_file & ~dest_file); // RULE2 RULE4
      end
      else if (is_bclr)
      begin
        res = src & ~bit_mask; // RULE5
        wr_file = 1'b1;
      end
      else if (is_bset)
      begin
        res = src | bit_mask; // RULE6
        wr_file = 1'b1;
      end
      else if (is_btst)
      begin
        skip_d = ~src[bit_idx]; // RULE7 RULE8
      end
    end
  end

  // next working register and flags
  always @*
  begin
    acc_d = acc_q;
    carry_d = carry_q;
    digit_carry_d = digit_carry_q;
    zero_d = zero_q;
    if (wr_acc)
      acc_d = res;
    if (go & (do_add | do_and))
      zero_d = (res == 8'h00); // RULE12 RULE2 RULE4
    if (go & do_add)
    begin
      carry_d = full_sum[8]; // RULE12
      digit_carry_d = low_sum[4]; // RULE12
    end
  end

  // skip sequencing
  always @*
  begin
    state_d = ST_RUN;
    case (state_q)
      ST_RUN:
      begin
        if (skip_d)
          state_d = ST_NOP; // RULE8
      end
      ST_NOP:
      begin
        state_d = ST_RUN; // RULE9
      end
      default:
      begin
        state_d = ST_RUN;
      end
    endcase
  end

  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      acc_q <= `ABX_ACC_RST;
      carry_q <= `ABX_FLAG_RST;
      digit_carry_q <= `ABX_FLAG_RST;
      zero_q <= `ABX_FLAG_RST;
      state_q <= ST_RUN;
      file_we_q <= 1'b0;
      file_waddr_q <= 7'h00;
      file_wdata_q <= 8'h00;
      prescaler_clr_q <= 1'b0;
      illegal_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d; // RULE8 RULE9
      file_we_q <= wr_file;
      file_waddr_q <= file_addr;
      file_wdata_q <= res;
      prescaler_clr_q <= wr_file & prescaler_on_timer & hits_timer; // RULE11
      illegal_q <= go & ~is_known;
      acc_q <= acc_d;
      carry_q <= carry_d;
      digit_carry_q <= digit_carry_d;
      zero_q <= zero_d;
    end
  end
endmodule // abx_exec

/* File: tb/abx_exec_properties.sv */
// checker for the execution unit
`timescale 1ns/100ps
module abx_exec_properties (
  input wire clk_sys,
  input wire rst,
  input wire instr_valid,
  input wire [13:0] instr_word,
  input wire [7:0] file_rdata,
  input wire [7:0] acc_q,
  input wire zero_q,
  input wire file_we_q,
  input wire [6:0] file_waddr_q,
  input wire prescaler_clr_q,
  input wire skip_cycle
);
  wire go = instr_valid && !skip_cycle;
  wire plain_addr = instr_word[6:0] < 7'h05 || instr_word[6:0] > 7'h09;
  wire bit_test = go && plain_addr && instr_word[13:10] == 4'h6;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  chk_skip_taken: assert property (bit_test |=>
    skip_cycle == !$past(file_rdata[instr_word[9:7]])) else $error("skip");
  chk_skip_nop: assert property (skip_cycle |=> $stable(acc_q) && !skip_cycle)
    else $error("nop");
  chk_and_lit: assert property (go && instr_word[13:8] == 6'h39 |=>
    acc_q == ($past(acc_q) & $past(instr_word[7:0]))) else $error("and");
  chk_add_lit: assert property (go && instr_word[13:9] == 5'h1f |=>
    acc_q == $past(acc_q) + $past(instr_word[7:0])) else $error("add");
  chk_and_zero: assert property (go && instr_word[13:8] == 6'h39 |=>
    zero_q == (acc_q == 8'h00)) else $error("zero");
  chk_bit_flags: assert property (go && instr_word[13:12] == 2'h1 |=>
    $stable(zero_q)) else $error("flags");
  chk_presc_clear: assert property (prescaler_clr_q |->
    file_we_q && file_waddr_q == 7'h01) else $error("prescaler");
endmodule // abx_exec_properties
bind abx_exec abx_exec_properties chk_i (.clk_sys(clk_sys), .rst(rst),
  .instr_valid(instr_valid), .instr_word(instr_word), .file_rdata(file_rdata),
  .acc_q(acc_q), .zero_q(zero_q), .file_we_q(file_we_q), .file_waddr_q(file_waddr_q),
  .prescaler_clr_q(prescaler_clr_q), .skip_cycle(skip_cycle));

/* File: tb/testbench.sv */
// bench for the execution unit
`timescale 1ns/100ps
module testbench;
  reg clk_sys = 0, rst = 1, instr_valid = 0, c = 0, dc = 0, z = 0, sk = 0, st, pa = 0;
  reg [13:0] instr_word = 0, i;
  reg [7:0] file_rdata = 0, w = 0, o, r, pin = 8'h5a;
  reg [15:0] lf = 16'h9130;
  reg [15:0] q[$];
  integer error_cnt = 0, samples_checked = 0, n;
  wire we, skc, cq, dcq, zq, pc;
  wire [6:0] wa;
  wire [7:0] wd, acc;
  abx_exec dut (.clk_sys(clk_sys), .rst(rst), .instr_valid(instr_valid), .file_addr(),
    .instr_word(instr_word), .file_rdata(file_rdata), .pin_rdata(pin), .illegal_q(),
    .prescaler_on_timer(pa), .file_we_q(we), .file_waddr_q(wa), .file_wdata_q(wd),
    .prescaler_clr_q(pc), .acc_q(acc), .carry_q(cq), .digit_carry_q(dcq), .zero_q(zq),
    .skip_cycle(skc));
  initial forever #5 clk_sys = ~clk_sys;
  function [15:0] nx(input [15:0] v); nx = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]}; endfunction
  task chk(input [23:0] nm, input [15:0] sn, input [15:0] e);
    samples_checked = samples_checked + 1;
    error_cnt = error_cnt + (sn !== e);
    if (sn !== e) $display("[FAIL] %s exp %h got %h", nm, e, sn);
  endtask
  task results;
    $display("errors %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge clk_sys)
    if (we === 1'b1)
      chk("wrt", {pc, wa, wd}, q.pop_front());
  initial
  begin
    #9000 error_cnt = error_cnt + 1;
    results;
  end
  initial
  begin
    repeat (2) @(posedge clk_sys);
    #1 rst = 0;
    repeat (5) @(posedge clk_sys);
    #1;
    for (n = 0; n < 300; n = n + 1)
    begin
      do lf = nx(lf);
      while (!(lf[13:12] == 2'b01 && lf[11:10] != 2'b11 || lf[13:9] == 5'h1f ||
        lf[13:8] == 6'h39 || lf[13:8] == 6'h07 || lf[13:8] == 6'h05));
      i = lf[13:0];
      lf = nx(lf);
      pa = lf[15];
      instr_word = i;
      file_rdata = lf[7:0];
      instr_valid = 1;
      r = (i[6:0] >= 7'h05 && i[6:0] <= 7'h09) ? pin : lf[7:0];
      o = i[13] ? i[7:0] : r;
      st = sk | i[13] | ~i[7];
      if (sk)
        sk = 0;
      else if (i[13:12] == 2'b01)
      begin
        sk = i[11] & ~r[i[9:7]];
        r[i[9:7]] = i[10];
        st = i[11];
      end
      else
      begin
        if (i[10] & i[9])
        begin
          {c, r} = w + o;
          dc = w[3:0] + o[3:0] > 5'h0f;
        end
        else
          r = w & o;
        z = r == 8'h00;
        if (st) w = r;
      end
      if (!st) q.push_back({pa && i[6:0] == 7'h01, i[6:0], r});
      @(posedge clk_sys);
      #1;
      chk("acc", acc, w);
      chk("flg", {cq, dcq, zq}, {c, dc, z});
      chk("skp", skc, sk);
    end
    results;
  end
endmodule // testbench
